// ===== logic/asmc_ctrl.sv
// Host-side controller driving an asynchronous 32K x 8 static memory
`default_nettype none
// Functional notes
// - Write enable stays high for the whole of every read.
// - Chip select held low at least 8 ns before write ends.
// - Address stable at least 8 ns before write ends.
// - Write may end by write enable or select; later falling strobe starts it.
module asmc_ctrl
   import asmc_pkg::*;
(
   // Clock and reset
   input  wire logic                i_core_clk,
   input  wire logic                i_rstn,
   // User request
   input  wire logic                i_req,
   input  wire logic                i_we,
   input  wire logic [ADDR_W-1:0]   i_addr,
   input  wire logic [DATA_W-1:0]   i_wdata,
   output logic                     o_ready,
   output logic                     o_rvalid,
   output logic [DATA_W-1:0]        o_rdata,
   // Memory pins
   output logic [ADDR_W-1:0]        o_word_addr,
   output logic                     o_sel_n,
   output logic                     o_outen_n,
   output logic                     o_wren_n,
   input  wire logic [DATA_W-1:0]   i_data_pins,
   output logic [DATA_W-1:0]        o_data_pins,
   output logic                     o_data_pins_oe
);

   logic [1:0]              rst_sync;
   logic                    rstn;
   logic [DATA_W-1:0]       din_meta;
   logic [DATA_W-1:0]       din_sync;
   asmc_state_type          state;
   logic [3:0]              cnt;
   logic                    cnt_done;
   logic                    take;
   logic                    rd_done;
   logic                    wr_done;

   assign rstn     = rst_sync[1];
   assign cnt_done = (cnt == RST_CNT);
   assign take     = (state == ST_IDLE) && i_req && o_ready;
   assign rd_done  = (state == ST_READ) && cnt_done;
   assign wr_done  = (state == ST_WRITE) && cnt_done;

   // Count down by one, resting at zero
   function automatic logic [3:0] cnt_dec(input logic [3:0] value);
      logic [3:0] result;
      result = (value == RST_CNT) ? RST_CNT : value - 4'h1;
      return result;
   endfunction : cnt_dec

   // Wait count loaded when a transfer is taken
   function automatic logic [3:0] first_cnt(input logic write_req);
      return write_req ? CNT_REL : CNT_RD;
   endfunction : first_cnt

   // Reset release
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end

   // Data pin synchroniser
   always_ff @(posedge i_core_clk or negedge rstn) begin
      if (!rstn) begin
         din_meta <= RST_DATA;
         din_sync <= RST_DATA;
      end else begin
         din_meta <= i_data_pins;
         din_sync <= din_meta;
      end
   end

   // State sequence
   always_ff @(posedge i_core_clk or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (take && i_we) begin
                  state <= ST_WSETUP;
               end else if (take) begin
                  state <= ST_READ;
               end
            end
            ST_READ: begin
               if (cnt_done) begin
                  state <= ST_RDEND;
               end
            end
            ST_RDEND: begin
               // Wait for memory to release the bus
               if (cnt_done) begin
                  state <= ST_IDLE;
               end
            end
            ST_WSETUP: begin
               state <= ST_WRITE;
            end
            ST_WRITE: begin
               if (cnt_done) begin
                  state <= ST_WREC;
               end
            end
            ST_WREC: begin
               state <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Wait counter
   always_ff @(posedge i_core_clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= RST_CNT;
      end else begin
         case (state)
            ST_IDLE: begin
               if (take) begin
                  cnt <= first_cnt(i_we);
               end
            end
            ST_READ: begin
               cnt <= cnt_done ? CNT_REL : cnt_dec(cnt);
            end
            ST_RDEND: begin
               cnt <= cnt_dec(cnt);
            end
            ST_WSETUP: begin
               cnt <= CNT_WR;
            end
            ST_WRITE: begin
               cnt <= cnt_done ? CNT_REC : cnt_dec(cnt);
            end
            default: begin
               cnt <= cnt;
            end
         endcase
      end
   end

   // Request handshake
   always_ff @(posedge i_core_clk or negedge rstn) begin
      if (!rstn) begin
         o_ready <= 1'h0;
      end else begin
         o_ready <= (state == ST_IDLE) && !take;
      end
   end

   // Read data return
   always_ff @(posedge i_core_clk or negedge rstn) begin
      if (!rstn) begin
         o_rvalid <= 1'h0;
         o_rdata  <= RST_DATA;
      end else begin
         o_rvalid <= rd_done;
         if (rd_done) begin
            o_rdata <= din_sync;
         end
      end
   end

   // Memory address
   always_ff @(posedge i_core_clk or negedge rstn) begin
      if (!rstn) begin
         o_word_addr <= RST_ADDR;
      end else if (take) begin
         o_word_addr <= i_addr;
      end
   end

   // Chip select
   always_ff @(posedge i_core_clk or negedge rstn) begin
      if (!rstn) begin
         o_sel_n <= 1'h1;
      end else if (take) begin
         o_sel_n <= 1'h0;
      end else if (rd_done || (state == ST_WREC)) begin
         // Select drops one cycle after write enable rises
         o_sel_n <= 1'h1;
      end
   end

   // Output enable
   always_ff @(posedge i_core_clk or negedge rstn) begin
      if (!rstn) begin
         o_outen_n <= 1'h1;
      end else if (take) begin
         o_outen_n <= i_we;
      end else if (rd_done) begin
         o_outen_n <= 1'h1;
      end
   end

   // Write enable
   always_ff @(posedge i_core_clk or negedge rstn) begin
      if (!rstn) begin
         o_wren_n <= 1'h1;
      end else if (take && !i_we) begin
         o_wren_n <= 1'h1;
      end else if (state == ST_WSETUP) begin
         // Falls after select: the later strobe starts the write
         o_wren_n <= 1'h0;
      end else if (wr_done) begin
         o_wren_n <= 1'h1;
      end
   end

   // Write data
   always_ff @(posedge i_core_clk or negedge rstn) begin
      if (!rstn) begin
         o_data_pins <= RST_DATA;
      end else if (take && i_we) begin
         o_data_pins <= i_wdata;
      end
   end

   // Write data drive
   always_ff @(posedge i_core_clk or negedge rstn) begin
      if (!rstn) begin
         o_data_pins_oe <= 1'h0;
      end else if (state == ST_WSETUP) begin
         o_data_pins_oe <= 1'h1;
      end else if (state == ST_WREC) begin
         o_data_pins_oe <= 1'h0;
      end
   end

endmodule : asmc_ctrl
`default_nettype wire

// ===== logic/asmc_pkg.sv
// Package of timing constants and types for the static memory controller
`default_nettype none
package asmc_pkg;
   localparam int unsigned CLK_PERIOD_NS      = 10;
   localparam int unsigned ADDR_W             = 15;
   localparam int unsigned DATA_W             = 8;
   localparam int unsigned MEM_WORDS          = 32768;
   // Slower grade figures, ns
   localparam int unsigned READ_CYCLE_NS      = 12;
   localparam int unsigned READ_ACCESS_NS     = 12;
   localparam int unsigned SELECT_TO_WRITE_END = 8;
   localparam int unsigned ADDR_VALID_TO_WRITE_END = 8;
   localparam int unsigned WRITE_PULSE_NS     = 7;
   localparam int unsigned WRITE_RECOVERY_NS  = 1;
   localparam int unsigned DESELECT_TO_RELEASE_TIME = 6;
   localparam int unsigned OUTEN_OFF_RELEASE_TIME   = 6;
   localparam int unsigned WRITE_START_RELEASE_TIME = 6;
   // Cycle counts, least times rounded up, read wait one cycle more, at least one cycle
   localparam int unsigned RD_WAIT_CYC =
      (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
   localparam int unsigned WR_PULSE_CYC =
      (SELECT_TO_WRITE_END + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RELEASE_CYC =
      (DESELECT_TO_RELEASE_TIME + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RECOVER_CYC =
      (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] CNT_RD  = 4'(RD_WAIT_CYC);
   localparam logic [3:0] CNT_WR  = 4'(WR_PULSE_CYC);
   localparam logic [3:0] CNT_REL = 4'(RELEASE_CYC);
   localparam logic [3:0] CNT_REC = 4'(RECOVER_CYC);
   // Reset values
   localparam logic [3:0]        RST_CNT  = 4'h0;
   localparam logic [ADDR_W-1:0] RST_ADDR = 15'h0000;
   localparam logic [DATA_W-1:0] RST_DATA = 8'h00;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_READ   = 3'b001,
      ST_RDEND  = 3'b010,
      ST_WSETUP = 3'b011,
      ST_WRITE  = 3'b100,
      ST_WREC   = 3'b101
   } asmc_state_type;
endpackage : asmc_pkg
`default_nettype wire

// ===== verification/asmc_ctrl_asserts.sv
// Checker of the controller memory pins
`default_nettype none
module asmc_ctrl_asserts
   import asmc_pkg::*;
(
   input wire logic              i_core_clk,
   input wire logic              i_rstn,
   input wire logic [ADDR_W-1:0] o_word_addr,
   input wire logic              o_sel_n,
   input wire logic              o_outen_n,
   input wire logic              o_wren_n
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);
   a_read_wren_high: assert property (!o_outen_n |-> o_wren_n)
      else $error("write enable low in read");
   a_sel_before_end: assert property ($rose(o_wren_n) |-> !o_sel_n && !$past(o_sel_n, 2))
      else $error("select too short before write end");
   a_addr_stable: assert property (!o_wren_n |-> $stable(o_word_addr))
      else $error("address moved in write");
   a_end_by_wren: assert property ($rose(o_sel_n) |-> $past(o_wren_n))
      else $error("select left before write enable");
   a_pulse_len: assert property ($fell(o_wren_n) |-> !o_wren_n[*2] ##1 o_wren_n)
      else $error("write pulse length wrong");
   c_read: cover property ($fell(o_outen_n));
   c_write: cover property ($rose(o_wren_n));
   c_back: cover property ($rose(o_sel_n) ##[1:4] $fell(o_sel_n));
endmodule : asmc_ctrl_asserts
bind asmc_ctrl asmc_ctrl_asserts u_asmc_ctrl_asserts (.i_core_clk(i_core_clk),
   .i_rstn(i_rstn), .o_word_addr(o_word_addr), .o_sel_n(o_sel_n),
   .o_outen_n(o_outen_n), .o_wren_n(o_wren_n));
`default_nettype wire

// ===== verification/asmc_sram_model.sv
// Behavioural model of the static memory
`default_nettype none
module asmc_sram_model
   import asmc_pkg::*;
(
   input  wire logic [ADDR_W-1:0] i_word_addr,
   input  wire logic              i_sel_n,
   input  wire logic              i_outen_n,
   input  wire logic              i_wren_n,
   input  wire logic [DATA_W-1:0] i_data_pins,
   output logic      [DATA_W-1:0] o_data_pins,
   output logic                   o_drive
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W-1:0] mem [MEM_WORDS];
   logic [DATA_W-1:0] rd;
   logic [DATA_W-1:0] last = '0;
   logic              wr_act;
   logic              standby;
   assign standby = i_sel_n;
   assign wr_act = !i_sel_n && !i_wren_n;
   assign #3 o_drive = !i_sel_n && !i_outen_n && i_wren_n;
   assign #3 rd = mem[i_word_addr];
   assign o_data_pins = o_drive ? rd : ~last;
   always @(negedge wr_act) mem[i_word_addr] = i_data_pins;
   always @(o_data_pins) if (o_drive) last = o_data_pins;
endmodule : asmc_sram_model
`default_nettype wire

// ===== verification/asmc_ctrl_test.sv
// Self-checking bench of the memory controller
`default_nettype none
module asmc_ctrl_test import asmc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rstn = 0, req = 0, we = 0, ready, rvalid, sel_n, outen_n, wren_n, oe, drv;
   logic [ADDR_W-1:0] addr = '0, waddr, al [24];
   logic [DATA_W-1:0] wdata = '0, rdata, dq_c, dq_m, pins, expq [$];
   logic [DATA_W-1:0] shadow [logic [ADDR_W-1:0]];
   int n_fail = 0, compares = 0, cyc = 0;
   assign pins = oe ? dq_c : dq_m;
   asmc_ctrl u_asmc_ctrl (.i_core_clk(clk), .i_rstn(rstn), .i_req(req), .i_we(we),
      .i_addr(addr), .i_wdata(wdata), .o_ready(ready), .o_rvalid(rvalid), .o_rdata(rdata),
      .o_word_addr(waddr), .o_sel_n(sel_n), .o_outen_n(outen_n), .o_wren_n(wren_n),
      .i_data_pins(pins), .o_data_pins(dq_c), .o_data_pins_oe(oe));
   asmc_sram_model u_asmc_sram_model (.i_word_addr(waddr), .i_sel_n(sel_n),
      .i_outen_n(outen_n), .i_wren_n(wren_n), .i_data_pins(pins), .o_data_pins(dq_m),
      .o_drive(drv));
   initial forever #5 clk = ~clk;
   task automatic check(input logic [DATA_W-1:0] seen, exp, input string what);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic summarize();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : summarize
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(negedge clk);
      while (ready !== 1'b1) @(negedge clk);
      req = 1;
      we = w;
      addr = a;
      wdata = d;
      if (w) shadow[a] = d;
      else expq.push_back(shadow[a]);
      @(negedge clk);
      req = 0;
      we = 1'($urandom);
      addr = 15'($urandom);
      wdata = 8'($urandom);
   endtask : xfer
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (rvalid === 1'b1) check(rdata, expq.pop_front(), "rdata");
      if (rstn) check({7'h00, oe & drv}, 8'h00, "pins");
      if (ready === 1'b1) check({7'h00, sel_n}, 8'h01, "standby");
      if (cyc == 3000) begin
         n_fail++;
         summarize();
      end
   end
   initial begin
      void'($urandom(28));
      repeat (8) @(posedge clk);
      @(negedge clk);
      rstn = 1;
      foreach (al[i]) al[i] = (i == 0) ? 15'h0000 : (i == 1) ? 15'h7FFF : 15'($urandom);
      foreach (al[i]) xfer(1, al[i], 8'($urandom));
      foreach (al[i]) xfer(0, al[23 - i], 8'h00);
      xfer(1, al[5], 8'hA5);
      xfer(0, al[5], 8'h00);
      xfer(1, al[5], 8'h5A);
      xfer(1, al[6], 8'hFF);
      xfer(0, al[5], 8'h00);
      repeat (12) @(posedge clk);
      check({7'h00, expq.size() == 0}, 8'h01, "queue");
      summarize();
   end
endmodule : asmc_ctrl_test
`default_nettype wire
